/* hw/fdcpm_pkg.sv */
package fdcpm_pkg;
    // Command opcodes and the invalid-command result byte.
    localparam logic [7:0] OPC_MODE = 8'h01;
    localparam logic [7:0] OPC_IDENT = 8'h18;
    localparam logic [7:0] OPC_PERP = 8'h12;
    localparam logic [7:0] RES_INVALID = 8'h80;
    // Identification byte; upper nibble and version value are arbitrary.
    localparam logic [3:0] ID_UPPER = 4'h5;
    localparam logic [3:0] ID_VERSION = 4'h1;
    // Number of parameter bytes in the mode-setting command.
    localparam logic [2:0] MODE_PARAM_BYTES = 3'h4;
    // Field positions in the perpendicular-mode parameter byte.
    localparam int PERP_OW_POS = 7;
    localparam int PERP_DT_LSB = 2;
    localparam int PERP_GAP_POS = 1;
    localparam int PERP_WG_POS = 0;
    // Field positions in mode parameter bytes.
    localparam int MODE_SETTLE_LSB = 0;
    localparam int MODE_RG_POS = 2;
    localparam int MODE_PU_POS = 0;
    // Values after reset.
    localparam logic [3:0] SETTLE_MULT_RST = 4'h8;
    localparam logic [3:0] DRIVE_TYPE_RST = 4'h0;
    localparam logic [1:0] GAPWG_RST = 2'h0;
    // Data rate encodings.
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_300K = 2'h1;
    localparam logic [1:0] RATE_250K = 2'h2;
    localparam logic [1:0] RATE_1M = 2'h3;
    // GAP2 lengths in bytes.
    localparam logic [5:0] GAP2_FMT_STD = 6'h16;
    localparam logic [5:0] GAP2_FMT_1M = 6'h29;
    localparam logic [5:0] GAP2_RW_NONE = 6'h00;
    localparam logic [5:0] GAP2_RW_LOW = 6'h13;
    localparam logic [5:0] GAP2_RW_1M = 6'h26;
    // Clock and settle step times.
    localparam int CLK_HZ = 10000000;
    localparam int STEP_250K_US = 8000;
    localparam int STEP_300K_US = 6666;
    localparam int STEP_500K_US = 4000;
    localparam int STEP_1M_US = 2000;
    localparam int STEP_250K_CYC = STEP_250K_US * (CLK_HZ / 1000000);
    localparam int STEP_300K_CYC = STEP_300K_US * (CLK_HZ / 1000000);
    localparam int STEP_500K_CYC = STEP_500K_US * (CLK_HZ / 1000000);
    localparam int STEP_1M_CYC = STEP_1M_US * (CLK_HZ / 1000000);
endpackage

/* hw/fdcpm_settle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module fdcpm_settle_timer #(
    parameter logic [19:0] STEP_250K = 20'h13880,
    parameter logic [19:0] STEP_300K = 20'h10464,
    parameter logic [19:0] STEP_500K = 20'h09C40,
    parameter logic [19:0] STEP_1M = 20'h04E20
) (
    input wire logic core_clk, // Core clock.
    input wire logic reset, // Synchronous reset.
    input wire logic clk_en, // Clock enable.
    input wire logic start, // Start pulse.
    input wire logic [3:0] mult, // Settle multiplier.
    input wire logic [1:0] rate, // Data rate code.
    output logic busy, // Interval running.
    output logic done // One-cycle pulse at end.
);
    logic [19:0] step_len;
    logic [19:0] step_cnt_reg;
    logic [3:0] mult_cnt_reg;

    always_comb begin
        case (rate)
            fdcpm_pkg::RATE_250K: step_len = STEP_250K;
            fdcpm_pkg::RATE_300K: step_len = STEP_300K;
            fdcpm_pkg::RATE_500K: step_len = STEP_500K;
            default: step_len = STEP_1M;
        endcase
    end

    // Interval is mult steps; a multiplier of zero finishes at once.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy <= 1'b0;
            done <= 1'b0;
            step_cnt_reg <= 20'h00000;
            mult_cnt_reg <= 4'h0;
        end else if (clk_en) begin
            done <= 1'b0;
            if (start && !busy) begin
                if (mult == 4'h0) begin
                    done <= 1'b1;
                end else begin
                    busy <= 1'b1;
                    mult_cnt_reg <= mult;
                    step_cnt_reg <= step_len - 20'h00001;
                end
            end else if (busy) begin
                if (step_cnt_reg != 20'h00000) begin
                    step_cnt_reg <= step_cnt_reg - 20'h00001;
                end else if (mult_cnt_reg == 4'h1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    mult_cnt_reg <= mult_cnt_reg - 4'h1;
                    step_cnt_reg <= step_len - 20'h00001;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* hw/fdcpm_config.sv */
`timescale 1ns/1ps
`default_nettype none
module fdcpm_config (
    input wire logic core_clk, // Core clock, 10 MHz.
    input wire logic reset, // Hardware reset, synchronous, active high.
    input wire logic clk_en, // Clock enable; low freezes all state.
    input wire logic soft_reset, // Software reset pulse.
    input wire logic cmd_valid, // Command byte written by host.
    input wire logic [7:0] cmd_byte, // Command byte value.
    output logic result_valid, // Result byte ready pulse.
    output logic [7:0] result_byte, // Result byte value.
    input wire logic [1:0] data_rate, // Selected data rate code.
    input wire logic [1:0] drive_sel, // Selected logical drive.
    input wire logic seek_sense_done, // Implied seek and sense interrupt finished.
    output logic settle_busy, // Head settle interval running.
    output logic sector_search_go, // Pulse: settle done, start sector search.
    input wire logic disk_change_input, // Disk change pin.
    output logic disk_change, // Disk change seen by core logic.
    output logic sep_read_gate, // External read gate to data separator.
    output logic sep_read_gate_en, // Separator uses the external read gate.
    input wire logic mfm_data_normal, // Normal write data for the pump pin.
    input wire logic serial_data_in, // Internal serial data-in signal.
    output logic pump_output_pin, // Pump output pin.
    output logic drive_perp, // Selected drive is in perpendicular mode.
    output logic precomp_zero, // Force write precompensation to zero.
    output logic [5:0] gap2_format_len, // GAP2 bytes written by format.
    output logic [5:0] gap2_rewrite_len, // GAP2 bytes rewritten by write data.
    output logic [3:0] drive_type_bits, // Stored drive type bits.
    output logic [1:0] gap_wg_sel // Stored gap and write-gate select.
);
    typedef enum {ST_IDLE, ST_MODE, ST_PERP} fdcpm_cmd_t;
    fdcpm_cmd_t state_reg;
    logic [2:0] byte_cnt_reg;
    logic [3:0] settle_mult_reg;
    logic read_gate_diag_bit;
    logic pump_diag_bit;
    logic [1:0] dc_q1_reg;
    logic dc_sync_reg;
    logic settle_start;
    logic any_perp;
    logic at_1m;
    logic [3:0] dt_written;
    logic [1:0] gw_written;

    // Pin input passes three flops; the first two are each read only by the next.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dc_q1_reg <= 2'h0;
            dc_sync_reg <= 1'b0;
        end else if (clk_en) begin
            dc_q1_reg <= {dc_q1_reg[0], disk_change_input};
            dc_sync_reg <= dc_q1_reg[1];
        end
    end

    // Command byte sequencing; every byte in ST_IDLE is an opcode.
    always_ff @(posedge core_clk) begin
        if (reset || (clk_en && soft_reset)) begin
            state_reg <= ST_IDLE;
            byte_cnt_reg <= 3'h0;
        end else if (clk_en && cmd_valid) begin
            case (state_reg)
                ST_IDLE: begin
                    byte_cnt_reg <= 3'h0;
                    if (cmd_byte == fdcpm_pkg::OPC_MODE) begin
                        state_reg <= ST_MODE;
                    end else if (cmd_byte == fdcpm_pkg::OPC_PERP) begin
                        state_reg <= ST_PERP;
                    end
                end
                ST_MODE: begin
                    if (byte_cnt_reg == fdcpm_pkg::MODE_PARAM_BYTES - 3'h1) begin
                        state_reg <= ST_IDLE;
                    end
                    byte_cnt_reg <= byte_cnt_reg + 3'h1;
                end
                ST_PERP: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Results: identify byte or invalid answer; mode and perpendicular give none.
    always_ff @(posedge core_clk) begin
        if (reset || (clk_en && soft_reset)) begin
            result_valid <= 1'b0;
            result_byte <= 8'h00;
        end else if (clk_en) begin
            result_valid <= 1'b0;
            if (cmd_valid && state_reg == ST_IDLE) begin
                if (cmd_byte == fdcpm_pkg::OPC_IDENT) begin
                    result_valid <= 1'b1;
                    result_byte <= {fdcpm_pkg::ID_UPPER, fdcpm_pkg::ID_VERSION};
                end else if (cmd_byte != fdcpm_pkg::OPC_MODE &&
                             cmd_byte != fdcpm_pkg::OPC_PERP) begin
                    result_valid <= 1'b1;
                    result_byte <= fdcpm_pkg::RES_INVALID;
                end
            end
        end
    end

    // Mode fields: byte 3 holds the settle multiplier, byte 4 the diagnostic bits.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            settle_mult_reg <= fdcpm_pkg::SETTLE_MULT_RST;
            read_gate_diag_bit <= 1'b0;
            pump_diag_bit <= 1'b0;
        end else if (clk_en && cmd_valid && state_reg == ST_MODE) begin
            if (byte_cnt_reg == 3'h2) begin
                settle_mult_reg <= cmd_byte[fdcpm_pkg::MODE_SETTLE_LSB +: 4];
            end
            if (byte_cnt_reg == 3'h3) begin
                read_gate_diag_bit <= cmd_byte[fdcpm_pkg::MODE_RG_POS];
                pump_diag_bit <= cmd_byte[fdcpm_pkg::MODE_PU_POS];
            end
        end
    end

    // Drive type bits survive a software reset; only hardware reset clears them.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            drive_type_bits <= fdcpm_pkg::DRIVE_TYPE_RST;
        end else if (clk_en && !soft_reset && cmd_valid && state_reg == ST_PERP &&
                     cmd_byte[fdcpm_pkg::PERP_OW_POS]) begin
            drive_type_bits <= cmd_byte[fdcpm_pkg::PERP_DT_LSB +: 4];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            gap_wg_sel <= fdcpm_pkg::GAPWG_RST;
        end else if (clk_en) begin
            if (soft_reset) begin
                gap_wg_sel <= fdcpm_pkg::GAPWG_RST;
            end else if (cmd_valid && state_reg == ST_PERP) begin
                gap_wg_sel <= {cmd_byte[fdcpm_pkg::PERP_GAP_POS],
                               cmd_byte[fdcpm_pkg::PERP_WG_POS]};
            end
        end
    end

    // Mode resolution: a nonzero select pair overrides the per-drive bits.
    always_comb begin
        at_1m = (data_rate == fdcpm_pkg::RATE_1M);
        any_perp = 1'b0;
        drive_perp = drive_type_bits[drive_sel];
        case (gap_wg_sel)
            2'h0: any_perp = 1'b0;
            2'h1: any_perp = 1'b1;
            2'h3: any_perp = 1'b1;
            default: any_perp = 1'b0;
        endcase
        if (gap_wg_sel != 2'h0) begin
            drive_perp = any_perp;
        end
    end

    // Precomp is forced only for drives made perpendicular by their type bit.
    assign precomp_zero = (gap_wg_sel == 2'h0) && drive_type_bits[drive_sel];

    always_comb begin
        gap2_format_len = fdcpm_pkg::GAP2_FMT_STD;
        gap2_rewrite_len = fdcpm_pkg::GAP2_RW_NONE;
        if (gap_wg_sel == 2'h1) begin
            gap2_rewrite_len = fdcpm_pkg::GAP2_RW_LOW;
        end else if (gap_wg_sel == 2'h3) begin
            gap2_format_len = fdcpm_pkg::GAP2_FMT_1M;
            gap2_rewrite_len = fdcpm_pkg::GAP2_RW_1M;
        end else if (gap_wg_sel == 2'h0 && drive_type_bits[drive_sel]) begin
            if (at_1m) begin
                gap2_format_len = fdcpm_pkg::GAP2_FMT_1M;
                gap2_rewrite_len = fdcpm_pkg::GAP2_RW_1M;
            end else begin
                gap2_rewrite_len = fdcpm_pkg::GAP2_RW_LOW;
            end
        end
    end

    // Diagnostic pin steering.
    assign sep_read_gate_en = read_gate_diag_bit;
    assign sep_read_gate = read_gate_diag_bit & dc_sync_reg;
    assign disk_change = read_gate_diag_bit ? 1'b0 : dc_sync_reg;
    assign pump_output_pin = pump_diag_bit ? serial_data_in : mfm_data_normal;

    // Settle starts when seek and sense interrupt finish.
    assign settle_start = seek_sense_done;

    fdcpm_settle_timer #(
        .STEP_250K(20'(fdcpm_pkg::STEP_250K_CYC)),
        .STEP_300K(20'(fdcpm_pkg::STEP_300K_CYC)),
        .STEP_500K(20'(fdcpm_pkg::STEP_500K_CYC)),
        .STEP_1M(20'(fdcpm_pkg::STEP_1M_CYC))
    ) u_settle (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(settle_start),
        .mult(settle_mult_reg),
        .rate(data_rate),
        .busy(settle_busy),
        .done(sector_search_go)
    );

    // Command fields as written, so the checks below can compare against them.
    assign dt_written = cmd_byte[fdcpm_pkg::PERP_DT_LSB +: 4];
    assign gw_written = {cmd_byte[fdcpm_pkg::PERP_GAP_POS], cmd_byte[fdcpm_pkg::PERP_WG_POS]};

    property p_perp_no_result;
        @(posedge core_clk) disable iff (reset)
        (clk_en && cmd_valid && state_reg == ST_PERP) |=> !result_valid;
    endproperty
    a_perp_no_result: assert property (p_perp_no_result) else $error("perp gave result");

    property p_ident;
        @(posedge core_clk) disable iff (reset || soft_reset)
        (clk_en && cmd_valid && state_reg == ST_IDLE && cmd_byte == fdcpm_pkg::OPC_IDENT)
        |=> (result_valid && result_byte[3:0] == fdcpm_pkg::ID_VERSION);
    endproperty
    a_ident: assert property (p_ident) else $error("bad identify answer");

    property p_ow_hold;
        @(posedge core_clk) disable iff (reset)
        (clk_en && cmd_valid && state_reg == ST_PERP && !cmd_byte[7])
        |=> $stable(drive_type_bits);
    endproperty
    a_ow_hold: assert property (p_ow_hold) else $error("type bits changed");

    property p_soft_clear;
        @(posedge core_clk) disable iff (reset)
        (clk_en && soft_reset) |=> (gap_wg_sel == 2'h0 && $stable(drive_type_bits));
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft reset wrong");

    property p_override;
        @(posedge core_clk) disable iff (reset)
        (gap_wg_sel == 2'h2) |-> (!drive_perp && gap2_rewrite_len == 6'h00);
    endproperty
    a_override: assert property (p_override) else $error("reserved not conv");

    property p_gap_1m;
        @(posedge core_clk) disable iff (reset)
        (gap_wg_sel == 2'h3) |-> (gap2_format_len == 6'h29 && gap2_rewrite_len == 6'h26);
    endproperty
    a_gap_1m: assert property (p_gap_1m) else $error("1M gap lengths");

    property p_pump;
        @(posedge core_clk) disable iff (reset)
        pump_diag_bit |-> (pump_output_pin == serial_data_in);
    endproperty
    a_pump: assert property (p_pump) else $error("pump pin not steered");

    property p_settle_zero;
        @(posedge core_clk) disable iff (reset)
        (clk_en && settle_start && !settle_busy && settle_mult_reg == 4'h0)
        |=> sector_search_go;
    endproperty
    a_settle_zero: assert property (p_settle_zero) else $error("zero settle late");

    sequence s_id_opcode;
        clk_en && cmd_valid && state_reg == ST_IDLE && cmd_byte == fdcpm_pkg::OPC_IDENT;
    endsequence

    sequence s_id_answer;
        result_valid && result_byte == {fdcpm_pkg::ID_UPPER, fdcpm_pkg::ID_VERSION};
    endsequence

    property p_ident_byte;
        @(posedge core_clk) disable iff (reset || soft_reset)
        s_id_opcode |=> s_id_answer;
    endproperty
    a_ident_byte: assert property (p_ident_byte) else $error("identify byte wrong");

    property p_invalid;
        @(posedge core_clk) disable iff (reset || soft_reset)
        (clk_en && cmd_valid && state_reg == ST_IDLE && cmd_byte != fdcpm_pkg::OPC_IDENT &&
         cmd_byte != fdcpm_pkg::OPC_MODE && cmd_byte != fdcpm_pkg::OPC_PERP)
        |=> (result_valid && result_byte == fdcpm_pkg::RES_INVALID);
    endproperty
    a_invalid: assert property (p_invalid) else $error("unknown opcode answer");

    property p_ow_write;
        @(posedge core_clk) disable iff (reset || soft_reset)
        (clk_en && cmd_valid && state_reg == ST_PERP && cmd_byte[fdcpm_pkg::PERP_OW_POS])
        |=> (drive_type_bits == $past(dt_written));
    endproperty
    a_ow_write: assert property (p_ow_write) else $error("type bits not written");

    property p_sel_write;
        @(posedge core_clk) disable iff (reset || soft_reset)
        (clk_en && cmd_valid && state_reg == ST_PERP) |=> (gap_wg_sel == $past(gw_written));
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select not written");

    property p_conv;
        @(posedge core_clk) disable iff (reset)
        (gap_wg_sel == 2'h0 && !drive_type_bits[drive_sel])
        |-> (!drive_perp && !precomp_zero &&
             gap2_format_len == 6'h16 && gap2_rewrite_len == 6'h00);
    endproperty
    a_conv: assert property (p_conv) else $error("conventional drive wrong");

    property p_perp_500k;
        @(posedge core_clk) disable iff (reset)
        (gap_wg_sel == 2'h1)
        |-> (drive_perp && !precomp_zero &&
             gap2_format_len == 6'h16 && gap2_rewrite_len == 6'h13);
    endproperty
    a_perp_500k: assert property (p_perp_500k) else $error("select override wrong");

    property p_precomp;
        @(posedge core_clk) disable iff (reset)
        (gap_wg_sel == 2'h0 && drive_type_bits[drive_sel]) |-> (drive_perp && precomp_zero);
    endproperty
    a_precomp: assert property (p_precomp) else $error("precomp not forced");

    property p_read_gate;
        @(posedge core_clk) disable iff (reset)
        read_gate_diag_bit |-> (sep_read_gate_en && !disk_change && sep_read_gate == dc_sync_reg);
    endproperty
    a_read_gate: assert property (p_read_gate) else $error("read gate not steered");

    sequence s_settle_go;
        clk_en && settle_start && !settle_busy && settle_mult_reg != 4'h0;
    endsequence

    property p_settle_run;
        @(posedge core_clk) disable iff (reset)
        s_settle_go |=> (settle_busy && !sector_search_go);
    endproperty
    a_settle_run: assert property (p_settle_run) else $error("settle did not start");

    property p_hw_defaults;
        @(posedge core_clk)
        reset |=> (drive_type_bits == 4'h0 && gap_wg_sel == 2'h0 && settle_mult_reg == 4'h8);
    endproperty
    a_hw_defaults: assert property (p_hw_defaults) else $error("reset values wrong");
endmodule
`default_nettype wire

/* verif/fdcpm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the command port plus the seek sequencer that starts a settle.
module fdcpm_host_model (
    input wire logic core_clk, // Core clock.
    output logic cmd_valid, // Command byte strobe.
    output logic [7:0] cmd_byte, // Command byte value.
    output logic seek_sense_done // Seek and sense finished pulse.
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        seek_sense_done = 1'b0;
    end
    // Bytes go back to back with the strobe held, so it never drops and rises between the bytes of one command.
    task automatic cmd(input logic [7:0] b [5], input int n);
        cmd_valid = 1'b1;
        for (int i = 0; i < n; i++) begin
            cmd_byte = b[i];
            @(negedge core_clk);
        end
        cmd_valid = 1'b0;
        cmd_byte = ~cmd_byte;
    endtask
    task automatic seek();
        seek_sense_done = 1'b1;
        @(negedge core_clk);
        seek_sense_done = 1'b0;
    endtask
endmodule
`default_nettype wire

/* verif/fdcpm_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fdcpm_config_tb;
    typedef struct {
        logic [7:0] p; logic [1:0] rate; logic [1:0] sel; logic [3:0] dt; logic [1:0] gw;
        logic pf; logic pz; logic [5:0] fmt; logic [5:0] rw;
    } fdcpm_row_t;
    logic core_clk, reset, soft_reset, cmd_valid, result_valid, seek_sense_done;
    logic settle_busy, sector_search_go, disk_change_input, disk_change, sep_read_gate;
    logic sep_read_gate_en, mfm_data_normal, serial_data_in, pump_output_pin;
    logic drive_perp, precomp_zero, clk_en;
    logic [7:0] cmd_byte, result_byte;
    logic [1:0] data_rate, drive_sel, gap_wg_sel;
    logic [5:0] gap2_format_len, gap2_rewrite_len;
    logic [3:0] drive_type_bits;
    int err_total = 0;
    int checks_done = 0;
    int res_cnt = 0;
    int n0, n;
    fdcpm_row_t rows [8] = '{
        '{8'h86, 2'h3, 2'h0, 4'h1, 2'h2, 1'b0, 1'b0, 6'h16, 6'h00},
        '{8'h84, 2'h3, 2'h0, 4'h1, 2'h0, 1'b1, 1'b1, 6'h29, 6'h26},
        '{8'h84, 2'h0, 2'h0, 4'h1, 2'h0, 1'b1, 1'b1, 6'h16, 6'h13},
        '{8'h3C, 2'h3, 2'h1, 4'h1, 2'h0, 1'b0, 1'b0, 6'h16, 6'h00},
        '{8'h01, 2'h3, 2'h1, 4'h1, 2'h1, 1'b1, 1'b0, 6'h16, 6'h13},
        '{8'h03, 2'h2, 2'h2, 4'h1, 2'h3, 1'b1, 1'b0, 6'h29, 6'h26},
        '{8'hA0, 2'h1, 2'h3, 4'h8, 2'h0, 1'b1, 1'b1, 6'h16, 6'h13},
        '{8'h80, 2'h1, 2'h3, 4'h0, 2'h0, 1'b0, 1'b0, 6'h16, 6'h00}
    };
    fdcpm_config dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .soft_reset(soft_reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .result_valid(result_valid), .result_byte(result_byte), .data_rate(data_rate),
        .drive_sel(drive_sel), .seek_sense_done(seek_sense_done), .settle_busy(settle_busy),
        .sector_search_go(sector_search_go), .disk_change_input(disk_change_input),
        .disk_change(disk_change), .sep_read_gate(sep_read_gate),
        .sep_read_gate_en(sep_read_gate_en), .mfm_data_normal(mfm_data_normal),
        .serial_data_in(serial_data_in), .pump_output_pin(pump_output_pin),
        .drive_perp(drive_perp), .precomp_zero(precomp_zero),
        .gap2_format_len(gap2_format_len), .gap2_rewrite_len(gap2_rewrite_len),
        .drive_type_bits(drive_type_bits), .gap_wg_sel(gap_wg_sel));
    fdcpm_host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .seek_sense_done(seek_sense_done));
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (result_valid === 1'b1) begin
            res_cnt++;
        end
    end
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // The settle count is long, so the bound sits above one multiplier unit at the 1M rate.
    task automatic wait_go(output int cnt);
        cnt = 0;
        while (sector_search_go !== 1'b1 && cnt < 30000) begin
            @(negedge core_clk);
            cnt++;
        end
        if (cnt >= 30000) begin
            err_total++;
            test_done();
        end
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        err_total++;
        test_done();
    end
    initial begin
        reset = 1'b1;
        soft_reset = 1'b0;
        clk_en = 1'b1;
        data_rate = 2'h3;
        drive_sel = 2'h0;
        disk_change_input = 1'b1;
        mfm_data_normal = 1'b1;
        serial_data_in = 1'b0;
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        check({drive_type_bits, gap_wg_sel, result_valid, result_byte}, 20'h0);
        host.cmd('{fdcpm_pkg::OPC_PERP, 8'h80, 8'h00, 8'h00, 8'h00}, 2);
        // The pin needs three edges after reset to reach the synchroniser output.
        @(negedge core_clk);
        check({16'h0, pump_output_pin, sep_read_gate_en, sep_read_gate, disk_change}, 20'h9);
        $display("test reset done");
        foreach (rows[i]) begin
            data_rate = rows[i].rate;
            drive_sel = rows[i].sel;
            n0 = res_cnt;
            host.cmd('{fdcpm_pkg::OPC_PERP, rows[i].p, 8'h00, 8'h00, 8'h00}, 2);
            @(negedge core_clk);
            check({drive_type_bits, gap_wg_sel, drive_perp, precomp_zero, gap2_format_len,
                gap2_rewrite_len}, {rows[i].dt, rows[i].gw, rows[i].pf, rows[i].pz,
                rows[i].fmt, rows[i].rw});
            check(20'(res_cnt - n0), 20'h0);
        end
        $display("test perpendicular rows done");
        host.cmd('{fdcpm_pkg::OPC_IDENT, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
        check({11'h0, result_valid, result_byte},
            {11'h1, fdcpm_pkg::ID_UPPER, fdcpm_pkg::ID_VERSION});
        @(negedge core_clk);
        host.cmd('{8'h77, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
        check({11'h0, result_valid, result_byte}, {11'h1, fdcpm_pkg::RES_INVALID});
        $display("test identify done");
        host.cmd('{fdcpm_pkg::OPC_MODE, 8'h00, 8'h00, 8'h00, 8'h05}, 5);
        mfm_data_normal = 1'b0;
        serial_data_in = 1'b1;
        repeat (3) @(negedge core_clk);
        check({16'h0, pump_output_pin, sep_read_gate_en, sep_read_gate, disk_change}, 20'hE);
        serial_data_in = 1'b0;
        disk_change_input = 1'b0;
        repeat (3) @(negedge core_clk);
        check({16'h0, pump_output_pin, sep_read_gate_en, sep_read_gate, disk_change}, 20'h4);
        $display("test diagnostics done");
        host.seek();
        wait_go(n);
        check(20'(n), 20'h0);
        data_rate = 2'h3;
        host.cmd('{fdcpm_pkg::OPC_MODE, 8'h00, 8'h00, 8'h01, 8'h00}, 5);
        host.seek();
        check({19'h0, settle_busy}, 20'h1);
        wait_go(n);
        // Two cycles of slack above the step length cover where the start edge is counted.
        check(20'(n >= fdcpm_pkg::STEP_1M_CYC && n <= fdcpm_pkg::STEP_1M_CYC + 2), 20'h1);
        $display("test head settle done");
        host.cmd('{fdcpm_pkg::OPC_PERP, 8'h87, 8'h00, 8'h00, 8'h00}, 2);
        soft_reset = 1'b1;
        @(negedge core_clk);
        soft_reset = 1'b0;
        @(negedge core_clk);
        check({14'h0, drive_type_bits, gap_wg_sel}, 20'h4);
        // With the clock enable low a full command must leave the drive type bits and the gap and write-gate select alone.
        clk_en = 1'b0;
        host.cmd('{fdcpm_pkg::OPC_PERP, 8'hBF, 8'h00, 8'h00, 8'h00}, 2);
        check({14'h0, drive_type_bits, gap_wg_sel}, 20'h4);
        clk_en = 1'b1;
        reset = 1'b1;
        @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        check({drive_type_bits, gap_wg_sel, result_valid, result_byte}, 20'h0);
        $display("test resets done");
        test_done();
    end
endmodule
`default_nettype wire
